// *** verilog/uis_uart.sv ***
// uis_uart.sv: one uart channel behind an apb slave: special character
// detect, prioritised interrupt source, rx time-out, baud divider, dma
// ready pins, loop-back and sleep.
// assumes pclk is also the baud reference and all pins are synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "uis_params.svh"

module uis_uart (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rx_pin,
  output logic tx_pin,
  // modem pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic rts_n,
  output logic dtr_n,
  output logic user_output_1_n,
  output logic user_output_2_n,
  // dma ready pins, active low
  output logic rx_ready_pin_n,
  output logic tx_ready_pin_n,
  // interrupt and sleep
  input wire logic peer_sleep_en,
  output logic irq,
  output logic asleep
);

  // address match, used by every decode below
  function automatic logic at(input logic [7:0] a, input logic [7:0] o);
    at = (a == o);
  endfunction

  // trigger level from a two-bit select
  function automatic logic [5:0] trig(input logic [1:0] s, input logic tx);
    case (s)
      2'h0: trig = tx ? `UIS_TT0 : `UIS_RT0;
      2'h1: trig = tx ? `UIS_TT1 : `UIS_RT1;
      2'h2: trig = tx ? `UIS_TT2 : `UIS_RT2;
      default: trig = tx ? `UIS_TT3 : `UIS_RT3;
    endcase
  endfunction

  // registers
  uis_pkg::uis_byte_t irq_enable_reg;
  uis_pkg::uis_byte_t fifo_control_reg;
  uis_pkg::uis_byte_t line_control_reg;
  logic [4:0] modem_control_reg;
  uis_pkg::uis_byte_t divisor_low_byte;
  uis_pkg::uis_byte_t divisor_high_byte;
  uis_pkg::uis_byte_t feature_control_reg;
  uis_pkg::uis_byte_t special_char_reg;
  uis_pkg::uis_byte_t scratch_reg;
  // fifos
  uis_pkg::uis_byte_t rxm [0:31];
  uis_pkg::uis_byte_t txm [0:31];
  logic [`UIS_AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [5:0] rx_cnt, tx_cnt;
  // serial engines
  uis_pkg::uis_ser_t ts, rs;
  logic [7:0] tcnt, rcnt;
  logic [2:0] tbit, rbit;
  logic [7:0] tsh, rsh;
  logic tpar, rpar, tline, perr_q;
  logic [15:0] bcnt;
  // status
  logic oe, pe, fe, txe_pend, spc_pend, flow_pend, to_flag;
  logic [9:0] tocnt;
  logic [3:0] mi_q, mdelta;
  logic rts_q, dma_rx, dma_tx;
  logic [5:0] src_snap;

  // apb decode
  wire acc = psel & penable;
  wire acc_wr = acc & pwrite;
  wire acc_rd = acc & ~pwrite;
  wire wr_data = acc_wr & at(paddr, `UIS_A_DATA);
  wire wr_ie = acc_wr & at(paddr, `UIS_A_IE);
  wire wr_fifo = acc_wr & at(paddr, `UIS_A_FIFO);
  wire wr_line = acc_wr & at(paddr, `UIS_A_LINE);
  wire wr_mdm = acc_wr & at(paddr, `UIS_A_MDM);
  wire wr_divl = acc_wr & at(paddr, `UIS_A_DIVL);
  wire wr_divh = acc_wr & at(paddr, `UIS_A_DIVH);
  wire wr_feat = acc_wr & at(paddr, `UIS_A_FEAT);
  wire wr_spc = acc_wr & at(paddr, `UIS_A_SPC);
  wire wr_scr = acc_wr & at(paddr, `UIS_A_SCR);
  wire rd_data = acc_rd & at(paddr, `UIS_A_DATA);
  wire rd_src = acc_rd & at(paddr, `UIS_A_SRC);
  wire rd_lstat = acc_rd & at(paddr, `UIS_A_LSTAT);
  wire rd_mstat = acc_rd & at(paddr, `UIS_A_MSTAT);
  wire mapped = at(paddr, `UIS_A_DATA) | at(paddr, `UIS_A_IE)
    | at(paddr, `UIS_A_FIFO) | at(paddr, `UIS_A_SRC)
    | at(paddr, `UIS_A_LINE) | at(paddr, `UIS_A_MDM)
    | at(paddr, `UIS_A_LSTAT) | at(paddr, `UIS_A_MSTAT)
    | at(paddr, `UIS_A_DIVL) | at(paddr, `UIS_A_DIVH)
    | at(paddr, `UIS_A_FEAT) | at(paddr, `UIS_A_SPC)
    | at(paddr, `UIS_A_SCR);
  assign pready = 1'h1;
  assign pslverr = acc & ~mapped;

  // frame shape from the line settings
  wire enh = feature_control_reg[`UIS_FEAT_ENH];
  wire loop = modem_control_reg[`UIS_MDM_LOOP];
  wire pen = line_control_reg[`UIS_LINE_PEN];
  wire even = line_control_reg[`UIS_LINE_EVEN];
  wire [3:0] wl = {2'h0, line_control_reg[`UIS_LINE_WL]} + `UIS_WL_MIN;
  wire wl5 = (wl == `UIS_WL_MIN);
  wire [7:0] stop_t = !line_control_reg[`UIS_LINE_STOP] ? `UIS_STOP1 :
    (wl5 ? `UIS_STOP15 : `UIS_STOP2);
  wire [3:0] cbits = wl + 4'h1 + {3'h0, pen};
  wire [7:0] char_t = {cbits, 4'h0} + stop_t;
  wire [9:0] to_lim = 10'({2'h0, char_t} * `UIS_TO_CHARS);

  // fifo levels and triggers
  wire fifo_on = fifo_control_reg[`UIS_FIFO_EN];
  wire dma = fifo_control_reg[`UIS_FIFO_DMA];
  wire rx_empty = (rx_cnt == 6'h00);
  wire tx_empty = (tx_cnt == 6'h00);
  wire rx_full = (rx_cnt == `UIS_DEPTH);
  wire tx_full = (tx_cnt == `UIS_DEPTH);
  wire [5:0] rtrig = fifo_on ?
    trig(fifo_control_reg[`UIS_FIFO_RXT], 1'h0) : `UIS_TRIG1;
  wire [5:0] ttrig = !fifo_on ? `UIS_TRIG1 :
    (enh ? trig(fifo_control_reg[`UIS_FIFO_TXT], 1'h1) : `UIS_TT0);
  wire rx_clr = wr_fifo & pwdata[`UIS_FIFO_RXCLR];
  wire tx_clr = wr_fifo & pwdata[`UIS_FIFO_TXCLR];

  // baud divider
  // halted while asleep
  wire run = ~asleep;
  wire [15:0] div = {divisor_high_byte, divisor_low_byte};
  wire [15:0] bnext = bcnt + 16'h0001;
  wire tick = run & (bnext >= div);

  wire rline = loop ? tline : rx_pin;
  assign tx_pin = loop | (tline & ~line_control_reg[`UIS_LINE_BRK]);

  // modem inputs, loop-back taken from outputs
  wire [3:0] mi = loop ? {modem_control_reg[`UIS_MDM_OUT2],
    modem_control_reg[`UIS_MDM_OUT1], modem_control_reg[`UIS_MDM_DTR],
    modem_control_reg[`UIS_MDM_RTS]} : ~{cd_n, ri_n, dsr_n, cts_n};
  wire mchg = |(mi ^ mi_q);
  assign rts_n = loop | ~modem_control_reg[`UIS_MDM_RTS];
  assign dtr_n = loop | ~modem_control_reg[`UIS_MDM_DTR];
  assign user_output_1_n = loop | ~modem_control_reg[`UIS_MDM_OUT1];
  assign user_output_2_n = loop | ~modem_control_reg[`UIS_MDM_OUT2];

  // transmitter strobes
  wire bit_end = tick & (tcnt == {2'h0, `UIS_BIT_LAST})
    & (ts != uis_pkg::ser_stop); // stop bit has its own length
  wire tx_go = tick & (ts == uis_pkg::ser_idle) & ~tx_empty;
  wire tx_push = wr_data & ~tx_full;

  // receiver strobes
  wire rsamp = tick & (rcnt == {2'h0, `UIS_BIT_LAST});
  wire rx_done = rsamp & (rs == uis_pkg::ser_stop);
  wire [7:0] rch = rsh >> (`UIS_WL_MAX - wl);
  wire rx_pop = rd_data & ~rx_empty;
  wire rx_push = rx_done & ~rx_full;

  wire [7:0] wmask = 8'hff >> (`UIS_WL_MAX - wl);
  wire spc_hit = feature_control_reg[`UIS_FEAT_SPC]
    & (((rch ^ special_char_reg) & wmask) == 8'h00);

  // interrupt source priority
  // data and time-out share enable bit 0
  wire en_rx = irq_enable_reg[`UIS_IE_RX];
  wire p_ls = irq_enable_reg[`UIS_IE_LS] & (oe | pe | fe);
  wire p_rx = en_rx & (rx_cnt >= rtrig);
  wire p_to = en_rx & to_flag;
  // tx holding interrupt pending from reset
  wire p_txe = irq_enable_reg[`UIS_IE_TXE] & txe_pend;
  wire p_ms = irq_enable_reg[`UIS_IE_MS] & (|mdelta);
  wire p_spc = enh & irq_enable_reg[`UIS_IE_SPC] & spc_pend;
  wire p_flow = flow_pend;
  wire [5:0] src = p_ls ? `UIS_SRC_LS : p_rx ? `UIS_SRC_RX :
    p_to ? `UIS_SRC_TO : p_txe ? `UIS_SRC_TXE : p_ms ? `UIS_SRC_MS :
    p_spc ? `UIS_SRC_SPC : p_flow ? `UIS_SRC_FLOW : `UIS_SRC_NONE;
  assign irq = ~src[0];

  // flow pin rising edges
  wire cts_rise = mi_q[0] & ~mi[0];
  wire rts_rise = ~rts_q & rts_n;
  wire flow_ev = enh & ((irq_enable_reg[`UIS_IE_CTS] & cts_rise)
    | (irq_enable_reg[`UIS_IE_RTS] & rts_rise));

  wire slp_ok = enh & irq_enable_reg[`UIS_IE_SLP] & peer_sleep_en;
  wire quiet = ~mchg & rline & (rs == uis_pkg::ser_idle) & tx_empty
    & (ts == uis_pkg::ser_idle) & ~irq & rx_empty;
  wire wake = ~rline | wr_data | mchg;

  // read mux
  wire [7:0] lstat = {1'h0, tx_empty & (ts == uis_pkg::ser_idle),
    tx_empty, 1'h0, fe, pe, oe, ~rx_empty};
  wire [7:0] rmux =
    at(paddr, `UIS_A_DATA) ? rxm[rx_rp] :
    at(paddr, `UIS_A_IE) ? irq_enable_reg :
    at(paddr, `UIS_A_SRC) ? {{2{fifo_on}}, src} :
    at(paddr, `UIS_A_LINE) ? line_control_reg :
    at(paddr, `UIS_A_MDM) ? {3'h0, modem_control_reg} :
    at(paddr, `UIS_A_LSTAT) ? lstat :
    at(paddr, `UIS_A_MSTAT) ? {mi, mdelta} :
    at(paddr, `UIS_A_DIVL) ? divisor_low_byte :
    at(paddr, `UIS_A_DIVH) ? divisor_high_byte :
    at(paddr, `UIS_A_FEAT) ? feature_control_reg :
    at(paddr, `UIS_A_SPC) ? special_char_reg :
    at(paddr, `UIS_A_SCR) ? scratch_reg : 8'h00;

  // upper enable bits need the enhanced bit
  wire [7:0] next_ie = enh ? pwdata[7:0] :
    {irq_enable_reg[`UIS_IE_HI], pwdata[`UIS_IE_LO]};

  // read data captured in the setup phase, source snapshot alongside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      src_snap <= `UIS_SRC_NONE;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h000000, rmux};
      src_snap <= src;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= `UIS_RST_REG;
      fifo_control_reg <= `UIS_RST_REG;
      line_control_reg <= `UIS_RST_REG;
      modem_control_reg <= 5'h00;
      divisor_low_byte <= `UIS_RST_DIVL;
      divisor_high_byte <= `UIS_RST_REG;
      feature_control_reg <= `UIS_RST_REG;
      special_char_reg <= `UIS_RST_REG;
      scratch_reg <= `UIS_RST_SCR;
    end else begin
      if (wr_ie)
        irq_enable_reg <= next_ie;
      if (wr_fifo)
        fifo_control_reg <= pwdata[7:0] & `UIS_FIFO_KEEP;
      if (wr_line)
        line_control_reg <= pwdata[7:0];
      if (wr_mdm)
        modem_control_reg <= pwdata[`UIS_MDM_W];
      if (wr_divl)
        divisor_low_byte <= pwdata[7:0];
      if (wr_divh)
        divisor_high_byte <= pwdata[7:0];
      if (wr_feat)
        feature_control_reg <= pwdata[7:0];
      if (wr_spc)
        special_char_reg <= pwdata[7:0];
      if (wr_scr)
        scratch_reg <= pwdata[7:0];
    end
  end

  // baud counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bcnt <= 16'h0000;
    else if (tick)
      bcnt <= 16'h0000;
    else if (run)
      bcnt <= bnext;
  end

  // fifo storage
  always_ff @(posedge pclk) begin
    if (tx_push)
      txm[tx_wp] <= pwdata[7:0];
    if (rx_push)
      rxm[rx_wp] <= rch;
  end

  // fifo pointers and levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= 6'h00;
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= 6'h00;
    end else begin
      if (tx_clr) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= 6'h00;
      end else begin
        tx_wp <= tx_wp + `UIS_AW'(tx_push);
        tx_rp <= tx_rp + `UIS_AW'(tx_go);
        tx_cnt <= tx_cnt + 6'(tx_push) - 6'(tx_go);
      end
      if (rx_clr) begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt <= 6'h00;
      end else begin
        rx_wp <= rx_wp + `UIS_AW'(rx_push);
        rx_rp <= rx_rp + `UIS_AW'(rx_pop);
        rx_cnt <= rx_cnt + 6'(rx_push) - 6'(rx_pop);
      end
    end
  end

  // transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts <= uis_pkg::ser_idle;
      tcnt <= 8'h00;
      tbit <= 3'h0;
      tsh <= 8'h00;
      tpar <= 1'h0;
      tline <= 1'h1;
    end else begin
      if (tick)
        tcnt <= (bit_end | tx_go) ? 8'h00 : tcnt + 8'h01;
      case (ts)
        uis_pkg::ser_idle: if (tx_go) begin
          ts <= uis_pkg::ser_start;
          tsh <= txm[tx_rp];
          tline <= 1'h0;
        end
        uis_pkg::ser_start: if (bit_end) begin
          ts <= uis_pkg::ser_data;
          tbit <= 3'h0;
          tline <= tsh[0];
          tpar <= tsh[0];
        end
        uis_pkg::ser_data: if (bit_end) begin
          if ({1'h0, tbit} == wl - 4'h1) begin
            ts <= pen ? uis_pkg::ser_par : uis_pkg::ser_stop;
            tline <= pen ? (tpar ^ ~even) : 1'h1;
          end else begin
            tbit <= tbit + 3'h1;
            tsh <= tsh >> 1;
            tline <= tsh[1];
            tpar <= tpar ^ tsh[1];
          end
        end
        uis_pkg::ser_par: if (bit_end) begin
          ts <= uis_pkg::ser_stop;
          tline <= 1'h1;
        end
        uis_pkg::ser_stop: if (tick & (tcnt == stop_t - 8'h01)) begin
          ts <= uis_pkg::ser_idle;
          tcnt <= 8'h00;
        end
        default: ts <= uis_pkg::ser_idle;
      endcase
    end
  end

  // receiver, start bit checked at its centre
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs <= uis_pkg::ser_idle;
      rcnt <= 8'h00;
      rbit <= 3'h0;
      rsh <= 8'h00;
      rpar <= 1'h0;
      perr_q <= 1'h0;
    end else if (tick) begin
      rcnt <= rsamp ? 8'h00 : rcnt + 8'h01;
      case (rs)
        uis_pkg::ser_idle: begin
          rcnt <= 8'h00;
          if (!rline)
            rs <= uis_pkg::ser_start;
        end
        uis_pkg::ser_start: if (rcnt == {2'h0, `UIS_HALF}) begin
          rcnt <= 8'h00;
          rbit <= 3'h0;
          rpar <= 1'h0;
          rs <= rline ? uis_pkg::ser_idle : uis_pkg::ser_data;
        end
        uis_pkg::ser_data: if (rsamp) begin
          rsh <= {rline, rsh[7:1]};
          rpar <= rpar ^ rline;
          rbit <= rbit + 3'h1;
          perr_q <= 1'h0;
          if ({1'h0, rbit} == wl - 4'h1)
            rs <= pen ? uis_pkg::ser_par : uis_pkg::ser_stop;
        end
        uis_pkg::ser_par: if (rsamp) begin
          perr_q <= rpar ^ rline ^ ~even;
          rs <= uis_pkg::ser_stop;
        end
        uis_pkg::ser_stop: if (rsamp)
          rs <= uis_pkg::ser_idle;
        default: rs <= uis_pkg::ser_idle;
      endcase
    end
  end

  // line errors, sticky until the status read; a new error wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe <= 1'h0;
      pe <= 1'h0;
      fe <= 1'h0;
    end else begin
      oe <= (rx_done & rx_full) | (oe & ~rd_lstat);
      pe <= (rx_done & perr_q) | (pe & ~rd_lstat);
      fe <= (rx_done & ~rline) | (fe & ~rd_lstat);
    end
  end

  // rx time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tocnt <= 10'h000;
      to_flag <= 1'h0;
    // restart at stop centre or data read
    end else if (rx_done | rd_data | rx_empty) begin
      tocnt <= 10'h000;
      to_flag <= 1'h0;
    end else if (tick & ~to_flag) begin
      tocnt <= tocnt + 10'h001;
      if (tocnt == to_lim - 10'h001)
        to_flag <= 1'h1;
    end
  end

  // sticky sources cleared by the source read that reported them
  wire clr_txe = wr_data | (rd_src & (src_snap == `UIS_SRC_TXE));
  wire clr_spc = rd_src & (src_snap == `UIS_SRC_SPC);
  wire clr_flow = rd_src & (src_snap == `UIS_SRC_FLOW);
  wire txe_ev = (tx_go & (tx_cnt == 6'h01))
    | (wr_ie & pwdata[`UIS_IE_TXE] & tx_empty);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_pend <= 1'h1;
      spc_pend <= 1'h0;
      flow_pend <= 1'h0;
      rts_q <= 1'h1;
    end else begin
      txe_pend <= txe_ev | (txe_pend & ~clr_txe);
      spc_pend <= (rx_done & spc_hit) | (spc_pend & ~clr_spc);
      flow_pend <= flow_ev | (flow_pend & ~clr_flow);
      rts_q <= rts_n;
    end
  end

  // modem deltas work the same in loop-back
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mdm
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mi_q[gi] <= 1'h0;
          mdelta[gi] <= 1'h0;
        end else begin
          mi_q[gi] <= mi[gi];
          mdelta[gi] <= (mi[gi] ^ mi_q[gi]) | (mdelta[gi] & ~rd_mstat);
        end
      end
    end
  endgenerate

  // dma ready pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rx <= 1'h1;
      dma_tx <= 1'h0;
    end else begin
      // rx: high on empty, low at trigger or time-out
      if (rx_empty)
        dma_rx <= 1'h1;
      else if ((rx_cnt >= rtrig) | to_flag)
        dma_rx <= 1'h0;
      // tx: high on full, low below trigger
      if (tx_full)
        dma_tx <= 1'h1;
      else if (tx_cnt < ttrig)
        dma_tx <= 1'h0;
    end
  end
  assign rx_ready_pin_n = dma ? dma_rx : rx_empty;
  assign tx_ready_pin_n = dma ? dma_tx : ~tx_empty;

  // sleep state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      asleep <= 1'h0;
    else if (!slp_ok)
      asleep <= 1'h0;
    // wake on start, load or modem change
    else if (asleep & wake)
      asleep <= 1'h0;
    else if (!asleep & quiet)
      asleep <= 1'h1;
  end

endmodule
`default_nettype wire

// *** verilog/uis_params.svh ***
// uis_params.svh: addresses, field positions, reset values and timing
// constants of the uis uart channel; definitions only, no logic.
// assumes every uis design file includes it by its bare name.
`ifndef UIS_PARAMS_SVH
`define UIS_PARAMS_SVH
// register byte addresses
`define UIS_A_DATA 8'h00
`define UIS_A_IE 8'h04
`define UIS_A_FIFO 8'h08
`define UIS_A_SRC 8'h0c
`define UIS_A_LINE 8'h10
`define UIS_A_MDM 8'h14
`define UIS_A_LSTAT 8'h18
`define UIS_A_MSTAT 8'h1c
`define UIS_A_DIVL 8'h20
`define UIS_A_DIVH 8'h24
`define UIS_A_FEAT 8'h28
`define UIS_A_SPC 8'h2c
`define UIS_A_SCR 8'h30
// reset values
`define UIS_RST_REG 8'h00
`define UIS_RST_SCR 8'hff
`define UIS_RST_DIVL 8'h01
// field positions
`define UIS_IE_RX 0
`define UIS_IE_TXE 1
`define UIS_IE_LS 2
`define UIS_IE_MS 3
`define UIS_IE_SLP 4
`define UIS_IE_SPC 5
`define UIS_IE_RTS 6
`define UIS_IE_CTS 7
`define UIS_IE_LO 3:0
`define UIS_IE_HI 7:4
`define UIS_FEAT_ENH 4
`define UIS_FEAT_SPC 5
`define UIS_FIFO_EN 0
`define UIS_FIFO_RXCLR 1
`define UIS_FIFO_TXCLR 2
`define UIS_FIFO_DMA 3
`define UIS_FIFO_TXT 5:4
`define UIS_FIFO_RXT 7:6
`define UIS_FIFO_KEEP 8'hf9
`define UIS_LINE_WL 1:0
`define UIS_LINE_STOP 2
`define UIS_LINE_PEN 3
`define UIS_LINE_EVEN 4
`define UIS_LINE_BRK 6
`define UIS_MDM_DTR 0
`define UIS_MDM_RTS 1
`define UIS_MDM_OUT1 2
`define UIS_MDM_OUT2 3
`define UIS_MDM_LOOP 4
`define UIS_MDM_W 4:0
// interrupt source codes, bit 0 high means none pending
`define UIS_SRC_NONE 6'h01
`define UIS_SRC_LS 6'h06
`define UIS_SRC_RX 6'h04
`define UIS_SRC_TO 6'h0c
`define UIS_SRC_TXE 6'h02
`define UIS_SRC_MS 6'h00
`define UIS_SRC_SPC 6'h10
`define UIS_SRC_FLOW 6'h20
// fifo geometry
`define UIS_DEPTH 6'h20
`define UIS_AW 5
// timing in 16x ticks; time-out in characters, word lengths in bits
`define UIS_BIT_LAST 6'h0f
`define UIS_HALF 6'h07
`define UIS_STOP1 8'h10
`define UIS_STOP15 8'h18
`define UIS_STOP2 8'h20
`define UIS_TO_CHARS 10'h004
`define UIS_WL_MIN 4'h5
`define UIS_WL_MAX 4'h8
// trigger levels
`define UIS_RT0 6'h08
`define UIS_RT1 6'h10
`define UIS_RT2 6'h18
`define UIS_RT3 6'h1c
`define UIS_TT0 6'h10
`define UIS_TT1 6'h08
`define UIS_TT2 6'h18
`define UIS_TT3 6'h1e
`define UIS_TRIG1 6'h01
`endif

// *** verilog/uis_pkg.sv ***
// uis_pkg.sv: types shared by the uis uart channel
// assumes the constants come from uis_params.svh
package uis_pkg;
  // position within a serial frame
  typedef enum {ser_idle, ser_start, ser_data, ser_par, ser_stop} uis_ser_t;
  typedef logic [7:0] uis_byte_t;
endpackage

// *** verif/uis_uart_chk.sv ***
// uis_uart_chk.sv: port-level checker for uis_uart
// assumes the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module uis_chk (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // pins
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic dsr_n,
  input wire logic rts_n,
  input wire logic peer_sleep_en,
  input wire logic irq,
  input wire logic asleep
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  logic lb;
  // mirror of the loop-back bit as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lb <= 1'b0;
    else if (acc && pwrite && paddr == 8'h14) lb <= pwdata[4];
  end
  a_err_access: assert property (pslverr |-> acc)
    else $error("error flag outside access");
  a_err_unmapped: assert property (acc && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access not flagged");
  a_lb_pins_high: assert property (lb |-> tx_pin && rts_n)
    else $error("pins active in loop-back");
  a_sleep_peer: assert property ($rose(asleep) |-> $past(peer_sleep_en))
    else $error("slept without peer enable");
  a_sleep_quiet: assert property ($rose(asleep) |-> $past(rx_pin) && !$past(irq))
    else $error("slept while busy");
  a_asleep_tx_idle: assert property (asleep |-> tx_pin)
    else $error("tx active while asleep");
  a_wake_start: assert property (asleep && !rx_pin |-> ##[1:4] !asleep)
    else $error("no wake on start bit");
  a_wake_write: assert property (asleep && acc && pwrite && paddr == 8'h00
    |-> ##[1:3] !asleep)
    else $error("no wake on data write");
  a_wake_modem: assert property (asleep && $changed(dsr_n) |-> ##[1:4] !asleep)
    else $error("no wake on modem change");
endmodule
bind uis_uart uis_chk i_uis_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .rx_pin, .tx_pin, .dsr_n, .rts_n, .peer_sleep_en,
  .irq, .asleep);
`default_nettype wire

// *** verif/uis_peer.sv ***
// uis_peer.sv: remote serial device on the rx and tx lines
// assumes divisor 1, so one bit lasts 16 clocks
`timescale 1ns/10ps
`default_nettype none
module uis_peer (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic tx_pin,
  output logic rx_pin
);
  localparam int BIT = 16;
  logic [7:0] got; // last byte heard on tx
  initial rx_pin = 1'b1;
  // start bit, n data bits lsb first, one stop bit
  task automatic send(input logic [7:0] b, input int n);
    rx_pin <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_pin <= b[i];
      repeat (BIT) @(posedge clk);
    end
    rx_pin <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // sample each tx bit at its centre
  always begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = tx_pin;
    end
    repeat (BIT) @(posedge clk);
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// tb.sv: self-checking bench for the uis uart channel
// assumes uis_peer on the serial lines and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, dsr_n, peer_sleep_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, r;
  wire [31:0] prdata;
  wire pready, rx_pin, tx_pin, rx_rdy_n, irq, asleep;
  wire tx_rdy_n, rts_n, dtr_n, user_output_1_n, user_output_2_n;
  // modem output pins, rts first
  wire [3:0] mpins = {rts_n, dtr_n, user_output_1_n, user_output_2_n};
  int n_fail = 0;
  int compares = 0;
  uis_uart i_uis_uart (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(), .rx_pin, .tx_pin, .cts_n(1'b1),
    .dsr_n, .cd_n(1'b1), .ri_n(1'b1), .rts_n, .dtr_n,
    .user_output_1_n, .user_output_2_n, .rx_ready_pin_n(rx_rdy_n),
    .tx_ready_pin_n(tx_rdy_n), .peer_sleep_en, .irq, .asleep);
  uis_peer i_uis_peer (.clk(pclk), .tx_pin, .rx_pin);
  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic finish_test;
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic t_reset;
    rd(8'h30, 8'hff);
    rd(8'h20, 8'h01);
    rd(8'h24, 8'h00);
    rd(8'h3c, 8'h00);
    wr(8'h04, 8'h02);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    rd(8'h0c, 8'h02);
  endtask
  task automatic t_special;
    wr(8'h28, 8'h30);
    wr(8'h2c, 8'hf3);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h20);
    i_uis_peer.send(8'h13, 5);
    chk("rx ready", 0, rx_rdy_n);
    rd(8'h0c, 8'h10);
    rd(8'h00, 8'h13);
  endtask
  task automatic t_timeout;
    wr(8'h10, 8'h03);
    wr(8'h08, 8'h09);
    wr(8'h04, 8'h01);
    i_uis_peer.send(8'ha5, 8);
    chk("rx ready", 1, rx_rdy_n);
    repeat (600) @(posedge pclk);
    rd(8'h0c, 8'hc1);
    repeat (60) @(posedge pclk);
    rd(8'h0c, 8'hcc);
    chk("rx ready", 0, rx_rdy_n);
    rd(8'h00, 8'ha5);
    rd(8'h18, 8'h60);
    repeat (700) @(posedge pclk);
    rd(8'h0c, 8'hc1);
    chk("rx ready", 1, rx_rdy_n);
  endtask
  task automatic t_loop;
    wr(8'h04, 8'h08);
    apb(1'b0, 8'h1c, 32'h0);
    wr(8'h14, 8'h1a);
    chk("modem pins", 4'hf, mpins);
    rd(8'h0c, 8'hc0);
    rd(8'h1c, 8'h99);
    wr(8'h00, 8'h5a);
    wr(8'h00, 8'hc3);
    chk("tx ready", 0, tx_rdy_n);
    wr(8'h08, 8'h01);
    chk("tx ready", 1, tx_rdy_n);
    repeat (400) @(posedge pclk);
    rd(8'h00, 8'h5a);
    rd(8'h00, 8'hc3);
    wr(8'h14, 8'h0a);
    chk("modem pins", 4'h6, mpins);
    apb(1'b0, 8'h1c, 32'h0);
  endtask
  task automatic t_sleep;
    wr(8'h04, 8'h10);
    repeat (50) @(posedge pclk);
    chk("asleep", 0, asleep);
    peer_sleep_en <= 1'b1;
    repeat (50) @(posedge pclk);
    chk("asleep", 1, asleep);
    i_uis_peer.send(8'h3c, 8);
    chk("asleep", 0, asleep);
    rd(8'h00, 8'h3c);
    repeat (50) @(posedge pclk);
    chk("asleep", 1, asleep);
    wr(8'h00, 8'h96);
    repeat (250) @(posedge pclk);
    chk("peer byte", 8'h96, i_uis_peer.got);
    chk("asleep", 1, asleep);
    dsr_n <= 1'b0;
    repeat (20) @(posedge pclk);
    wr(8'h04, 8'h00);
    wr(8'h20, 8'h01);
    repeat (50) @(posedge pclk);
    chk("asleep", 0, asleep);
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, dsr_n, peer_sleep_en} = 3'b010;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_special;
    t_timeout;
    t_loop;
    t_sleep;
    finish_test;
  end
  // hang guard
  initial begin
    repeat (10000) @(posedge pclk);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
